// ==== core/bbs_host.sv ====
// host-side controller driving a battery-backed 32K x 8 static ram over its pins
// assumes i_power_good comes from an external supervisor; pin levels settle by the next edge
`timescale 1ns/1ps
`default_nettype none
module bbs_host
  import bbs_pkg::*;
#(
  parameter int unsigned RECOV_CYCLES = bbs_pkg::CYC_RECOV,
  parameter int unsigned PF_CYCLES    = bbs_pkg::CYC_PF_DELAY,
  parameter bit          TWO_WIRE     = 1'b0
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  // user request side
  input  wire logic                      i_req,
  input  wire logic                      i_we,
  input  wire logic [bbs_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [bbs_pkg::DATA_W-1:0] i_wdata,
  output logic                           o_ready,
  output logic                           o_rvalid,
  output logic [bbs_pkg::DATA_W-1:0]     o_rdata,
  output logic                           o_busy,
  // supply supervisor, high while supply is above threshold
  input  wire logic                      i_power_good,
  // memory pins
  output logic [bbs_pkg::ADDR_W-1:0]     o_address_lines,
  output logic                           o_sel_n,
  output logic                           o_strobe_n,
  output logic                           o_gate_n,
  input  wire logic [bbs_pkg::DATA_W-1:0] i_data_io_bus,
  output logic [bbs_pkg::DATA_W-1:0]     o_data_io_bus,
  output logic                           o_data_io_oe
);
  bbs_sync_if sif ();
  bbs_pin_sync #(.W(9)) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_raw     ({i_power_good, i_data_io_bus}),
    .sync      (sif)
  );

  bbs_state_t state_q;
  bbs_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              we_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rvalid_q;
  logic              sel_n_q;
  logic              strobe_n_q;
  logic              gate_n_q;
  logic              oe_q;
  logic              ready_q;
  logic              busy_q;

  // larger of two counts, so a load never cuts a longer pending wait short
  function automatic logic [31:0] max_cnt(input logic [31:0] a, input logic [31:0] b);
    return (a > b) ? a : b;
  endfunction

  wire pwr_ok     = sif.power_good;
  wire cnt_done   = (cnt_q == 32'd0);
  wire take_req   = (state_q == BBS_IDLE) && i_req && pwr_ok;
  // the write flag must be known at the take edge, before we_q has loaded
  wire we_next    = take_req ? i_we : we_q;
  // a read takes the later of address, select and gate access; all start together here
  wire [31:0] rd_cycles = 32'(CYC_READ);
  // write pulse must also cover data setup before the rising edge
  wire [31:0] wr_cycles = max_cnt(32'(CYC_WPULSE), 32'(CYC_WDATA));
  wire [31:0] cnt_dec   = cnt_done ? 32'd0 : (cnt_q - 32'd1);
  // recovery after a drop also covers the late deselect of a fast supply fall
  wire [31:0] pf_load    = 32'(RECOV_CYCLES + PF_CYCLES);
  wire [31:0] recov_hold = max_cnt(cnt_q, 32'(RECOV_CYCLES));
  wire        pf_abort   = !pwr_ok && (state_q != BBS_RECOVER);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_dec;
    case (state_q)
      BBS_RECOVER: begin
        // select and strobe stay high until the supply has been good for the full wait
        if (!pwr_ok) begin
          // keep a longer power-fail wait pending while the supply is still low
          cnt_d = recov_hold;
        end else if (cnt_done) begin
          state_d = BBS_IDLE;
        end
      end
      BBS_IDLE: begin
        if (take_req && i_we) begin
          // gate is lowered in two-wire mode, so let the device float first
          state_d = TWO_WIRE ? BBS_FLOAT : BBS_WRITE;
          cnt_d   = TWO_WIRE ? 32'(CYC_FLOAT) : wr_cycles;
        end else if (take_req) begin
          state_d = BBS_READ;
          cnt_d   = rd_cycles;
        end
      end
      BBS_READ: begin
        if (cnt_done) begin
          state_d = BBS_GAP;
          cnt_d   = 32'(CYC_GAP);
        end
      end
      BBS_FLOAT: begin
        if (cnt_done) begin
          state_d = BBS_WRITE;
          cnt_d   = wr_cycles;
        end
      end
      BBS_WRITE: begin
        if (cnt_done) begin
          state_d = BBS_GAP;
          cnt_d   = 32'(CYC_GAP);
        end
      end
      BBS_GAP: begin
        if (cnt_done) begin
          state_d = BBS_IDLE;
        end
      end
      default: begin
        state_d = BBS_RECOVER;
        cnt_d   = 32'(RECOV_CYCLES);
      end
    endcase
    // a supply drop aborts any cycle; the device ignores pins meanwhile
    if (pf_abort) begin
      state_d = BBS_RECOVER;
      cnt_d   = pf_load;
    end
  end

  wire in_write   = (state_d == BBS_WRITE);
  wire in_float   = (state_d == BBS_FLOAT);
  wire in_read    = (state_d == BBS_READ);
  wire sel_n_d    = !(in_read || in_write || in_float);
  wire strobe_n_d = !(in_write || in_float);
  wire gate_n_d   = TWO_WIRE ? (state_d == BBS_RECOVER) : !in_read;
  // drive data only during the strobe after the device has floated
  wire oe_d       = in_write && we_next;
  // the filter delay is already counted into the read length
  wire sample_rd  = (state_q == BBS_READ) && cnt_done;
  wire ready_d    = (state_d == BBS_IDLE) && pwr_ok;
  wire busy_d     = !ready_d;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= BBS_RECOVER;
      cnt_q   <= 32'(RECOV_CYCLES);
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_q  <= '0;
      wdata_q <= '0;
      we_q    <= 1'b0;
    end else if (take_req) begin
      // address and data are held for the whole cycle
      addr_q  <= i_addr;
      wdata_q <= i_wdata;
      we_q    <= i_we;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_n_q    <= 1'b1;
      strobe_n_q <= 1'b1;
      gate_n_q   <= 1'b1;
      oe_q       <= 1'b0;
    end else begin
      sel_n_q    <= sel_n_d;
      strobe_n_q <= strobe_n_d;
      gate_n_q   <= gate_n_d;
      oe_q       <= oe_d;
    end
  end

  // busy has its own flop so both status outputs come straight from registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_q <= 1'b0;
      busy_q  <= 1'b1;
    end else begin
      ready_q <= ready_d;
      busy_q  <= busy_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= sample_rd;
      if (sample_rd) begin
        rdata_q <= sif.data;
      end
    end
  end

  assign o_address_lines = addr_q;
  assign o_data_io_bus   = wdata_q;
  assign o_data_io_oe    = oe_q;
  assign o_sel_n         = sel_n_q;
  assign o_strobe_n      = strobe_n_q;
  assign o_gate_n        = gate_n_q;
  assign o_ready         = ready_q;
  assign o_busy          = busy_q;
  assign o_rvalid        = rvalid_q;
  assign o_rdata         = rdata_q;
endmodule
`default_nettype wire

// ==== core/bbs_pkg.sv ====
// constants and types for the host-side battery-backed sram port controller
// assumes a single 40 MHz clock and an asynchronous byte-wide static ram outside
// What this block does
// - host holds address through write and deasserts between cycles
// - host gives write data setup before end; it stops driving on the same edge that the strobe rises
// - gate may stay low, but host must avoid bus contention
// - host keeps select and strobe inactive 5 ms after power-up
package bbs_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned ADDR_W        = 15;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned NUM_BYTES     = 32768;
  // fast grade timings in ns; recovery in ms, power-fail delay in us
  localparam int unsigned T_ADDR_ACC_NS = 70;
  localparam int unsigned T_SEL_ACC_NS  = 70;
  localparam int unsigned T_GATE_ACC_NS = 35;
  localparam int unsigned T_FLOAT_NS    = 25;
  localparam int unsigned T_WPULSE_NS   = 50;
  localparam int unsigned T_WDATA_NS    = 30;
  localparam int unsigned T_CYCLE_NS    = 70;
  localparam int unsigned T_RECOV_MS    = 5;
  localparam int unsigned T_PF_DELAY_US = 200;
  localparam int unsigned CLK_PS        = 1_000_000_000 / (CLK_HZ / 1000);
  // bus data reaches the controller three edges late through the input filter
  localparam int unsigned SYNC_LAT      = 3;
  function automatic int unsigned ns_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned CYC_READ      = ns_up(T_ADDR_ACC_NS) + SYNC_LAT;
  localparam int unsigned CYC_FLOAT     = ns_up(T_FLOAT_NS);
  localparam int unsigned CYC_WPULSE    = ns_up(T_WPULSE_NS);
  localparam int unsigned CYC_WDATA     = ns_up(T_WDATA_NS);
  localparam int unsigned CYC_GAP       = ns_up(T_CYCLE_NS);
  localparam int unsigned CYC_RECOV     = (T_RECOV_MS * (CLK_HZ / 1000));
  localparam int unsigned CYC_PF_DELAY  = (T_PF_DELAY_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  typedef enum logic [5:0] {
    BBS_RECOVER = 6'b00_0001,
    BBS_IDLE    = 6'b00_0010,
    BBS_READ    = 6'b00_0100,
    BBS_FLOAT   = 6'b00_1000,
    BBS_WRITE   = 6'b01_0000,
    BBS_GAP     = 6'b10_0000
  } bbs_state_t;
endpackage

// ==== core/bbs_sync_if.sv ====
// carrier for synchronised pin levels between the input filter and the controller
// assumes both ends run on i_clk
`timescale 1ns/1ps
`default_nettype none
interface bbs_sync_if;
  logic [7:0] data;
  logic       power_good;
  modport src (output data, output power_good);
  modport dst (input data, input power_good);
endinterface
`default_nettype wire

// ==== core/bbs_pin_sync.sv ====
// three-stage synchroniser for pins coming from outside the clock domain
// assumes i_clk is the controller clock; stage one feeds only stage two
`timescale 1ns/1ps
`default_nettype none
module bbs_pin_sync #(
  parameter int unsigned W = 9
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // raw pins
  input  wire logic [W-1:0] i_raw,
  // filtered result
  bbs_sync_if.src           sync
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire  [W-1:0] agree_mask = ~(s2_q ^ s3_q);
  wire  [W-1:0] out_d      = (agree_mask & s2_q) | (~agree_mask & out_q);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= i_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
  assign sync.data       = out_q[7:0];
  assign sync.power_good = out_q[8];
endmodule
`default_nettype wire

// ==== test/bbs_host_props.sv ====
// assertions on the host pins of the sram port controller
// assumes one clock domain, bound onto every bbs_host
`timescale 1ns/1ps
`default_nettype none
module bbs_host_props #(
  parameter int unsigned RECOV_CYCLES = 20
) (
  // clock, reset, requests
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [14:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        o_ready,
  input  wire logic        o_rvalid,
  input  wire logic        i_power_good,
  // memory pins
  input  wire logic [14:0] o_address_lines,
  input  wire logic        o_sel_n,
  input  wire logic        o_strobe_n,
  input  wire logic        o_gate_n,
  input  wire logic [7:0]  o_data_io_bus,
  input  wire logic        o_data_io_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [31:0] pg_cnt_q;
  wire         take_rd = o_ready && i_req && !i_we;
  wire         take_wr = o_ready && i_req && i_we;
  // counts cycles of good supply; saturates so a long run cannot wrap
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n || !i_power_good) pg_cnt_q <= 32'h0000_0000;
    else if (pg_cnt_q != 32'hFFFF_FFFF) pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
  end
  chk_addr_held: assert property (!o_sel_n && $past(!o_sel_n) |-> $stable(o_address_lines))
    else $error("address moved during access");
  chk_ctrl_gap: assert property ($rose(o_sel_n) |-> o_sel_n[*3])
    else $error("select reasserted too soon");
  chk_wdata_setup: assert property ($rose(o_strobe_n) |-> $past(o_data_io_oe, 2) && $past(o_data_io_oe)
    && $past(o_data_io_bus, 2) == $past(o_data_io_bus))
    else $error("write data not set up before strobe rise");
  chk_no_clash: assert property (o_data_io_oe |-> !(!o_gate_n && !o_sel_n && o_strobe_n))
    else $error("host drives bus during read");
  chk_recov_wait: assert property ($fell(o_sel_n) |-> pg_cnt_q > RECOV_CYCLES)
    else $error("select before recovery wait");
  chk_pf_release: assert property ($fell(i_power_good) |-> ##[0:6] (o_sel_n && o_strobe_n && !o_data_io_oe))
    else $error("controls active after supply loss");
  chk_read_pins: assert property (take_rd |=> !o_sel_n && !o_gate_n && o_strobe_n && !o_data_io_oe
    && o_address_lines == $past(i_addr))
    else $error("read pins wrong");
  chk_read_answer: assert property (take_rd |-> ##8 o_rvalid)
    else $error("read answer late");
  chk_write_pins: assert property (take_wr |=> !o_sel_n && !o_strobe_n && o_data_io_oe
    && o_data_io_bus == $past(i_wdata) && o_address_lines == $past(i_addr))
    else $error("write pins wrong");
  cov_read: cover property (take_rd ##8 o_rvalid);
  cov_write: cover property (take_wr ##1 !o_strobe_n);
  cov_pf: cover property ($fell(i_power_good) ##1 !o_ready);
endmodule
bind bbs_host bbs_host_props #(.RECOV_CYCLES(RECOV_CYCLES)) u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid),
  .i_power_good(i_power_good), .o_address_lines(o_address_lines), .o_sel_n(o_sel_n),
  .o_strobe_n(o_strobe_n), .o_gate_n(o_gate_n), .o_data_io_bus(o_data_io_bus), .o_data_io_oe(o_data_io_oe));
`default_nettype wire

// ==== test/bbs_sram_model.sv ====
// behavioural 32k x 8 battery-backed static ram, fast grade
// assumes host levels on plain wires; resolves the shared data bus
`timescale 1ns/1ps
`default_nettype none
module bbs_sram_model (
  // host pins
  input  wire logic [14:0] i_address_lines,
  input  wire logic        i_sel_n,
  input  wire logic        i_strobe_n,
  input  wire logic        i_gate_n,
  input  wire logic [7:0]  i_host_data,
  input  wire logic        i_host_oe,
  input  wire logic        i_power_good,
  // resolved bus
  output logic [7:0]       o_bus
);
  logic [7:0] mem [0:32767];
  logic [7:0] last_q;
  realtime    t_addr;
  realtime    t_sel;
  realtime    t_gate;
  wire        drive = !i_sel_n && !i_gate_n && i_strobe_n && i_power_good;
  always @(i_address_lines) t_addr = $realtime;
  always @(negedge i_sel_n) t_sel = $realtime;
  always @(negedge i_gate_n) t_gate = $realtime;
  // 1 ns polling keeps access times visible without event races
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_q = 8'h00;
    t_addr = 0;
    t_sel = 0;
    t_gate = 0;
    forever begin
      #1;
      if (!i_sel_n && !i_strobe_n && i_power_good) mem[i_address_lines] = i_host_data;
      if (i_host_oe) o_bus = i_host_data;
      else if (drive && $realtime >= t_addr + 70 && $realtime >= t_sel + 70 && $realtime >= t_gate + 35) begin
        o_bus = mem[i_address_lines];
        last_q = o_bus;
      end
      else if (drive && $realtime < t_addr + 10) o_bus = last_q;
      else o_bus = ~last_q;
    end
  end
endmodule
`default_nettype wire

// ==== test/test_battery_backed_sram_port.sv ====
// self-checking bench: host controller against the ram model
// assumes shortened recovery counts; shadow array predicts reads
`timescale 1ns/1ps
`default_nettype none
module test_battery_backed_sram_port;
  import bbs_pkg::*;
  logic        i_clk;
  logic        i_reset_n;
  logic        i_req;
  logic        i_we;
  logic        i_power_good;
  logic        o_ready;
  logic        o_rvalid;
  logic        o_busy;
  logic        sel_n;
  logic        strobe_n;
  logic        gate_n;
  logic        oe;
  logic [14:0] i_addr;
  logic [14:0] pins_addr;
  logic [7:0]  i_wdata;
  logic [7:0]  o_rdata;
  logic [7:0]  bus;
  logic [7:0]  pins_data;
  logic [7:0]  shadow [0:32767];
  int          err_count;
  int          num_checks;
  bbs_host #(.RECOV_CYCLES(20), .PF_CYCLES(10)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_busy(o_busy), .i_power_good(i_power_good), .o_address_lines(pins_addr), .o_sel_n(sel_n),
    .o_strobe_n(strobe_n), .o_gate_n(gate_n), .i_data_io_bus(bus), .o_data_io_bus(pins_data), .o_data_io_oe(oe));
  bbs_sram_model u_ram (.i_address_lines(pins_addr), .i_sel_n(sel_n), .i_strobe_n(strobe_n), .i_gate_n(gate_n),
    .i_host_data(pins_data), .i_host_oe(oe), .i_power_good(i_power_good), .o_bus(bus));
  function automatic logic [7:0] exp_byte(input logic [14:0] a);
    return shadow[a];
  endfunction
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic access(input logic we, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    check("ready", 8'h01, {7'h00, o_ready});
    check("busy", 8'h00, {7'h00, o_busy});
    i_req = 1'b1;
    i_we = we;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_req = 1'b0;
    if (we) shadow[a] = d;
    else begin
      n = 0;
      while (o_rvalid !== 1'b1 && n < 20) begin
        @(negedge i_clk);
        n++;
      end
      check("rvalid", 8'h01, {7'h00, o_rvalid});
      check("rdata", exp_byte(a), o_rdata);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // a full run needs well under 3000 cycles
  initial begin
    #(25 * 20000);
    err_count++;
    end_of_test();
  end
  initial begin
    i_reset_n = 1'b0;
    i_req = 1'b0;
    i_we = 1'b0;
    i_addr = 15'h0000;
    i_wdata = 8'h00;
    i_power_good = 1'b1;
    err_count = 0;
    num_checks = 0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    void'($urandom(32'he953_7c2d));
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    access(1'b1, 15'h0000, 8'hA5);
    access(1'b1, 15'h7FFF, 8'h5A);
    access(1'b0, 15'h0000, 8'h00);
    access(1'b0, 15'h7FFF, 8'h00);
    // a small address pool makes reads hit earlier writes
    repeat (40) access(1'($urandom), 15'($urandom) & 15'h700F, 8'($urandom));
    i_power_good = 1'b0;
    repeat (8) @(negedge i_clk);
    check("ready", 8'h00, {7'h00, o_ready});
    check("busy", 8'h01, {7'h00, o_busy});
    i_req = 1'b1;
    i_we = 1'b1;
    i_addr = 15'h0000;
    i_wdata = 8'hFF;
    @(negedge i_clk);
    i_req = 1'b0;
    i_power_good = 1'b1;
    access(1'b0, 15'h0000, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
